// [hw/alu_slice_cfg.svh]
// constants for the 4-bit alu register slice: widths, opcodes, bit positions
// assumes inclusion by bare name from the package and the slice modules
`ifndef ALU_SLICE_CFG_SVH
`define ALU_SLICE_CFG_SVH

`define SLICE_W        4           // data width of one slice
`define SLICE_MSB      3           // sign bit position inside a slice
`define REG_CNT        8           // registers held by one slice
`define REG_SEL_W      3           // width of the register select field
`define OP_W           3           // width of the instruction field
`define OP_ADD_ONE     3'h0        // rx plus data plus one
`define OP_ADD         3'h1        // rx plus data
`define OP_AND         3'h2        // rx and data
`define OP_LOAD        3'h3        // data into rx
`define OP_OUT         3'h4        // rx to output register only
`define OP_OR          3'h5        // rx or data
`define OP_XOR         3'h6        // rx xor data
`define OP_LOAD_CPL    3'h7        // complement of data into rx
`define NIBBLE_ZERO    4'h0        // reset value of registers
`define RST_SYNC_INIT  2'h0        // reset synchroniser held value

`endif

// [hw/alu_slice_pkg.sv]
// types shared by the alu slice and its carry and status logic
// assumes alu_slice_cfg.svh sits on the include path
`include "alu_slice_cfg.svh"

package alu_slice_pkg;

	typedef logic [`SLICE_W-1:0]   nibble_t;   // one slice worth of data
	typedef logic [`REG_SEL_W-1:0] reg_sel_t;  // register address

	// instruction codes of the slice
	typedef enum logic [`OP_W-1:0] {
		OP_ADD_ONE  = `OP_ADD_ONE,
		OP_ADD      = `OP_ADD,
		OP_AND      = `OP_AND,
		OP_LOAD     = `OP_LOAD,
		OP_OUT      = `OP_OUT,
		OP_OR       = `OP_OR,
		OP_XOR      = `OP_XOR,
		OP_LOAD_CPL = `OP_LOAD_CPL
	} op_t;

	// arithmetic only when bits one and two are both low
	function automatic logic is_arith(input logic bit_one, input logic bit_two);
		is_arith = !bit_one && !bit_two;
	endfunction

endpackage

// [hw/carry_status_logic.sv]
// alu of one slice with carry chain, lookahead terms and array status
// assumes operands arrive active high and in the same clock domain;
// every output here is purely combinational
`timescale 1ns/100ps
`include "alu_slice_cfg.svh"

module carry_status_logic
	import alu_slice_pkg::*;
(
	input  wire nibble_t rx_i,            // register operand
	input  wire nibble_t data_i,          // bus operand, active high
	input  wire logic    bit0_i,          // instruction bit zero / carry in, low = carry
	input  wire logic    bit_one_i,       // instruction bit one
	input  wire logic    bit_two_i,       // instruction bit two
	input  wire logic    top_slice_i,     // this is the most significant slice
	output nibble_t      result_o,        // operation result
	output logic         ripple_carry_n_o,// ripple carry, low = carry of one
	output logic         propagate_n_o,   // propagate / negative status
	output logic         generate_n_o,    // generate / overflow status
	output logic         nonzero_o        // result is not all zero
);

	logic                arith;           // arithmetic op selected
	logic [`SLICE_W:0]   carry;           // carry chain, bit 0 is carry in
	nibble_t             prop;            // per bit propagate
	nibble_t             gen;             // per bit generate
	nibble_t             sum;             // adder output
	logic                grp_p;           // slice propagate
	logic                grp_g;           // slice generate
	logic                overflow;        // signed overflow of the result

	assign arith    = is_arith(bit_one_i, bit_two_i);
	// bit zero doubles as carry in whatever the slice position
	assign carry[0] = arith & ~bit0_i;

	// per bit carry chain
	genvar k;
	generate
		for (k = 0; k < `SLICE_W; k++) begin : g_bit
			assign prop[k]    = rx_i[k] | data_i[k];
			assign gen[k]     = rx_i[k] & data_i[k];
			assign sum[k]     = rx_i[k] ^ data_i[k] ^ carry[k];
			assign carry[k+1] = gen[k] | (prop[k] & carry[k]);
		end
	endgenerate

	assign grp_p = &prop;
	// generate term built without carry in, as a lookahead unit expects
	assign grp_g = gen[3] | (prop[3] & gen[2]) | (prop[3] & prop[2] & gen[1])
		| (prop[3] & prop[2] & prop[1] & gen[0]);

	// result selection by instruction code
	always_comb begin
		case (op_t'({bit_two_i, bit_one_i, bit0_i}))
			OP_ADD_ONE,
			OP_ADD:      result_o = sum;
			OP_AND:      result_o = rx_i & data_i;
			OP_LOAD:     result_o = data_i;
			OP_OUT:      result_o = rx_i;
			OP_OR:       result_o = rx_i | data_i;
			OP_XOR:      result_o = rx_i ^ data_i;
			OP_LOAD_CPL: result_o = ~data_i;
			default:     result_o = `NIBBLE_ZERO;
		endcase
	end

	// equal operand signs, opposite result sign
	assign overflow = (rx_i[`SLICE_MSB] == data_i[`SLICE_MSB])
		&& (result_o[`SLICE_MSB] != rx_i[`SLICE_MSB]);

	// carry out when arithmetic, else instruction bit zero passes through
	assign ripple_carry_n_o = arith ? ~carry[`SLICE_W] : bit0_i;

	// status outputs; top slice reports sign and overflow
	always_comb begin
		if (top_slice_i) begin
			propagate_n_o = ~result_o[`SLICE_MSB];
			generate_n_o  = ~overflow;
		end else if (arith) begin
			propagate_n_o = ~grp_p;
			generate_n_o  = ~grp_g;
		end else begin
			propagate_n_o = 1'b0;
			generate_n_o  = 1'b1;
		end
	end

	assign nonzero_o = |result_o;

endmodule

// [hw/alu_slice_top.sv]
// one cascadable 4-bit alu slice: register stack, output register,
// carry chain and status pins for ripple or lookahead arrays
// assumes neighbouring slices and the lookahead unit run on clk_i logic,
// so the chained pins are used unsynchronised; wire-or of zero is external
`timescale 1ns/100ps
`include "alu_slice_cfg.svh"

module alu_slice_top
	import alu_slice_pkg::*;
(
	input  wire logic     clk_i,                    // slice clock, 25 MHz
	input  wire logic     arst_n_i,                 // async reset, active low
	input  wire logic     clk_en_i,                 // freezes all state when low
	input  wire logic     execute_n_i,              // execute, active low
	input  wire reg_sel_t register_select_i,        // register address
	input  wire nibble_t  operand_in_n_i,           // bus operand, active low
	input  wire logic     instr_bit0_carry_in_i,    // instruction bit zero / carry in
	input  wire logic     instr_bit_one_i,          // instruction bit one
	input  wire logic     instr_bit_two_i,          // instruction bit two
	input  wire logic     top_slice_select_i,       // high on most significant slice
	input  wire logic     output_drive_enable_n_i,  // data bus enable, active low
	output nibble_t       data_out_n_o,             // output register, active low
	output logic          data_out_oe_o,            // data bus drive enable
	output logic          ripple_carry_n_o,         // ripple carry, active low
	output logic          propagate_n_o,            // propagate / negative
	output logic          generate_n_o,             // generate / overflow
	output logic          zero_o,                   // open drain zero level
	output logic          zero_oe_o                 // zero pin pulled low when high
);

	// reset synchroniser
	logic [1:0]  rst_sync;                         // release shift register
	logic [1:0]  next_rst_sync;                    // next synchroniser value
	logic        rst_n;                            // synchronised reset

	// register stack and output stage
	nibble_t     regs [`REG_CNT];                  // eight word stack
	nibble_t     next_regs [`REG_CNT];             // next stack contents
	nibble_t     out_reg;                          // output register, active high
	nibble_t     next_out_reg;                     // next output register
	logic        oe_reg;                           // registered bus enable
	logic        next_oe_reg;                      // next bus enable
	logic        zero_reg;                         // open drain level, held low
	logic        next_zero_reg;                    // next open drain level

	// datapath
	nibble_t     rx;                               // addressed register
	nibble_t     data;                             // bus operand, active high
	nibble_t     result;                           // alu result
	logic        nonzero;                          // result not zero
	logic        commit;                           // write back this edge

	assign rx     = regs[register_select_i];
	assign data   = ~operand_in_n_i;
	// execute gates only the stored results, never the chained pins
	assign commit = clk_en_i && !execute_n_i;

	// alu, carry chain and status; combinational so a ripple chain
	// settles in one cycle, at the cost of no output flop on these pins
	carry_status_logic u_carry_status (
		.rx_i             (rx),
		.data_i           (data),
		.bit0_i           (instr_bit0_carry_in_i),
		.bit_one_i        (instr_bit_one_i),
		.bit_two_i        (instr_bit_two_i),
		.top_slice_i      (top_slice_select_i),
		.result_o         (result),
		.ripple_carry_n_o (ripple_carry_n_o),
		.propagate_n_o    (propagate_n_o),
		.generate_n_o     (generate_n_o),
		.nonzero_o        (nonzero)
	);

	// open drain zero pin: never drives high, pulls low when nonzero
	assign zero_o    = zero_reg;
	assign zero_oe_o = nonzero;

	// reset release: next value of the synchroniser
	always_comb begin
		next_rst_sync = rst_sync;
		if (clk_en_i) begin
			next_rst_sync = {rst_sync[0], 1'b1};
		end
	end

	// reset release: registers, taking only constants under reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync <= `RST_SYNC_INIT;
		end else begin
			rst_sync <= next_rst_sync;
		end
	end

	assign rst_n = rst_sync[1];

	// next stack, output register and bus enable
	always_comb begin
		for (int i = 0; i < `REG_CNT; i++) begin
			next_regs[i] = regs[i];
		end
		next_out_reg  = out_reg;
		next_oe_reg   = oe_reg;
		next_zero_reg = 1'b0;
		if (commit) begin
			// result written back to the addressed register
			next_regs[register_select_i] = result;
			next_out_reg                 = result;
		end
		if (clk_en_i) begin
			// bus enable follows its pin one cycle late
			next_oe_reg = !output_drive_enable_n_i;
		end
	end

	// stack and output stage registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `REG_CNT; i++) begin
				regs[i] <= `NIBBLE_ZERO;
			end
			out_reg  <= `NIBBLE_ZERO;
			oe_reg   <= 1'b0;
			zero_reg <= 1'b0;
		end else begin
			for (int i = 0; i < `REG_CNT; i++) begin
				regs[i] <= next_regs[i];
			end
			out_reg  <= next_out_reg;
			oe_reg   <= next_oe_reg;
			zero_reg <= next_zero_reg;
		end
	end

	assign data_out_n_o  = ~out_reg;
	assign data_out_oe_o = oe_reg;

	// ------------------------------------------------------------------
	// checks on the slice's own outputs and its internal alu result
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	logic    arith_chk;                            // arithmetic op present
	logic    cin_chk;                              // carry in, active high
	logic [4:0] wide_sum;                          // reference sum with carry

	assign arith_chk = !instr_bit_one_i && !instr_bit_two_i;
	assign cin_chk   = !instr_bit0_carry_in_i;
	assign wide_sum  = {1'b0, rx} + {1'b0, data} + {4'h0, cin_chk};

	sequence s_commit;
		!execute_n_i && clk_en_i;
	endsequence

	// the value is taken at the commit edge, the output one cycle later
	sequence s_stored(nibble_t v);
		##1 (~data_out_n_o == $past(v));
	endsequence

	chk_arith_carry_out: assert property (
		arith_chk |-> (ripple_carry_n_o == !wide_sum[4]))
		else $error("ripple carry does not match slice carry");

	chk_logic_passthru: assert property (
		!arith_chk |-> (ripple_carry_n_o == instr_bit0_carry_in_i))
		else $error("bit zero not passed to ripple carry");

	chk_negative_flag: assert property (
		top_slice_select_i |-> (propagate_n_o == !result[`SLICE_MSB]))
		else $error("negative status wrong on top slice");

	chk_overflow_flag: assert property (
		(top_slice_select_i && rx[`SLICE_MSB] == data[`SLICE_MSB])
		|-> (generate_n_o == (result[`SLICE_MSB] == rx[`SLICE_MSB])))
		else $error("overflow status wrong on top slice");

	chk_lookahead_terms: assert property (
		(!top_slice_select_i && arith_chk)
		|-> (propagate_n_o == !(&(rx | data))))
		else $error("propagate term wrong on lower slice");

	chk_sum_result: assert property (
		arith_chk |-> (result == wide_sum[3:0]))
		else $error("sum does not use bit zero as carry");

	chk_logic_lookahead: assert property (
		(!top_slice_select_i && !arith_chk) |-> (!propagate_n_o && generate_n_o))
		else $error("lower slice lookahead not forced on logic op");

	chk_no_exec_effect: assert property (
		($stable(rx) && $stable(operand_in_n_i) && $stable(instr_bit0_carry_in_i)
		&& $stable(instr_bit_one_i) && $stable(instr_bit_two_i)
		&& $stable(top_slice_select_i))
		|-> ($stable(ripple_carry_n_o) && $stable(propagate_n_o)
		&& $stable(generate_n_o)))
		else $error("carry pins changed without an input change");

	chk_zero_pulldown: assert property (
		(zero_oe_o == (result != `NIBBLE_ZERO)) && !zero_o)
		else $error("zero pin drive wrong");

	chk_result_stored: assert property (
		s_commit |-> s_stored(result))
		else $error("result not loaded into output register");

endmodule

// [test/far_side_model.sv]
// far side of one slice: pull-up on the zero line and one lookahead carry stage
// assumes propagate and generate arrive as active-low terms, carry low = one
`timescale 1ns/100ps

module far_side_model (
	input  wire logic zero_i,               // zero pin level driven by the slice
	input  wire logic zero_oe_i,            // slice sinks the zero pin
	input  wire logic propagate_n_i,        // propagate from the slice
	input  wire logic generate_n_i,         // generate from the slice
	input  wire logic carry_in_n_i,         // carry into the group, low = carry
	output logic      zero_line_o,          // wired zero level of the array
	output logic      lookahead_carry_n_o   // carry towards the next bit zero
);
	// pull-up wins unless some slice sinks the line
	assign zero_line_o = zero_oe_i ? zero_i : 1'b1;
	// propagate low with generate high hands the carry in straight on
	assign lookahead_carry_n_o = generate_n_i & (propagate_n_i | carry_in_n_i);
endmodule

// [test/tb_alu_slice_top.sv]
// testbench of one alu slice: store path, carry chain and status pins
// assumes a single 25 MHz clock; the far side model closes the zero line
`timescale 1ns/100ps

module tb_alu_slice_top;
	import alu_slice_pkg::*;

	logic     clk_i;           // slice clock
	logic     arst_n_i;        // async reset, active low
	logic     clk_en_i;        // clock enable
	logic     execute_n_i;     // execute, active low
	reg_sel_t sel;             // register address
	nibble_t  operand_in_n_i;  // bus operand, active low
	logic     bit0;            // instruction bit zero, also carry in
	logic     bit1;            // instruction bit one
	logic     bit2;            // instruction bit two
	logic     top_sel;         // most significant slice flag
	logic     oe_n;            // data bus enable, active low
	nibble_t  data_out_n_o;    // output register
	logic     data_out_oe_o;   // data bus drive
	logic     ripple_n;        // ripple carry
	logic     prop_n;          // propagate or negative
	logic     gen_n;           // generate or overflow
	logic     zero_o;          // zero pin data
	logic     zero_oe_o;       // zero pin sink
	logic     zero_line;       // wired zero level
	logic     la_carry_n;      // lookahead carry out of the model
	int       mismatches;      // failed comparisons
	int       comparisons;     // comparisons made

	alu_slice_top u_alu_slice_top (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
		.execute_n_i(execute_n_i), .register_select_i(sel),
		.operand_in_n_i(operand_in_n_i), .instr_bit0_carry_in_i(bit0),
		.instr_bit_one_i(bit1), .instr_bit_two_i(bit2),
		.top_slice_select_i(top_sel), .output_drive_enable_n_i(oe_n),
		.data_out_n_o(data_out_n_o), .data_out_oe_o(data_out_oe_o),
		.ripple_carry_n_o(ripple_n), .propagate_n_o(prop_n), .generate_n_o(gen_n),
		.zero_o(zero_o), .zero_oe_o(zero_oe_o)
	);

	// bit zero of the slice is also the group carry in of the lookahead stage
	far_side_model u_far_side_model (
		.zero_i(zero_o), .zero_oe_i(zero_oe_o), .propagate_n_i(prop_n),
		.generate_n_i(gen_n), .carry_in_n_i(bit0), .zero_line_o(zero_line),
		.lookahead_carry_n_o(la_carry_n)
	);

	// free running clock, 40 ns period
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic check_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_nib(input string what, input nibble_t exp, input nibble_t got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one microcycle of stimulus, launched 1 ns after the rising edge
	task automatic apply(input reg_sel_t s, input logic [2:0] op, input nibble_t d,
		input logic ex_n);
		@(posedge clk_i);
		#1;
		sel = s;
		{bit2, bit1, bit0} = op;
		operand_in_n_i = ~d;
		execute_n_i = ex_n;
	endtask

	function automatic nibble_t exp_res(input logic [2:0] op, input nibble_t r, input nibble_t d);
		case (op)
			3'h0: exp_res = r + d + 4'h1;
			3'h1: exp_res = r + d;
			3'h2: exp_res = r & d;
			3'h3: exp_res = d;
			3'h4: exp_res = r;
			3'h5: exp_res = r | d;
			3'h6: exp_res = r ^ d;
			default: exp_res = ~d;
		endcase
	endfunction

	// combinational pins against values worked out from operands and op
	task automatic check_pins(input nibble_t r, input nibble_t d, input logic [2:0] op,
		input logic top);
		logic [4:0] s;
		logic       arith;
		logic       gen;
		logic       ovf;
		nibble_t    res;
		arith = (op[2:1] == 2'h0);
		s = {1'b0, r} + {1'b0, d} + {4'h0, ~op[0]};
		gen = ({1'b0, r} + {1'b0, d}) > 5'h0F;
		res = exp_res(op, r, d);
		ovf = (r[3] == d[3]) && (res[3] != r[3]);
		#5;
		check_bit("ripple", arith ? ~s[4] : op[0], ripple_n);
		if (top) begin
			check_bit("negative", ~res[3], prop_n);
			check_bit("overflow", ~ovf, gen_n);
		end else begin
			check_bit("propagate", arith ? ~&(r | d) : 1'b0, prop_n);
			check_bit("generate", arith ? ~gen : 1'b1, gen_n);
			// group carry out of the lookahead stage equals the slice carry out
			check_bit("lookahead", arith ? ~s[4] : op[0], la_carry_n);
		end
		check_bit("zero", res == 4'h0, zero_line);
	endtask

	// load r, then every op against d without committing
	task automatic sweep(input logic top, input nibble_t r, input nibble_t d);
		apply(3'h5, 3'h3, r, 1'b0);
		for (int op = 0; op < 8; op++) begin
			apply(3'h5, op[2:0], d, 1'b1);
			check_pins(r, d, op[2:0], top);
		end
	endtask

	task automatic test_store();
		oe_n = 1'b0;
		apply(3'h2, 3'h3, 4'h9, 1'b0);
		apply(3'h2, 3'h4, 4'h0, 1'b0);
		check_nib("load out", ~4'h9, data_out_n_o);
		check_bit("bus enable", 1'b1, data_out_oe_o);
		apply(3'h2, 3'h3, 4'h6, 1'b1);
		check_nib("output op", ~4'h9, data_out_n_o);
		oe_n = 1'b1;
		apply(3'h2, 3'h4, 4'h0, 1'b1);
		check_nib("refused", ~4'h9, data_out_n_o);
		check_pins(4'h9, 4'h0, 3'h4, 1'b0);
		check_bit("bus disable", 1'b0, data_out_oe_o);
		$display("test store done");
	endtask

	task automatic test_lower_slice();
		top_sel = 1'b0;
		sweep(1'b0, 4'hF, 4'h1);
		sweep(1'b0, 4'h7, 4'h8);
		sweep(1'b0, 4'h0, 4'h0);
		sweep(1'b0, 4'hA, 4'h5);
		$display("test lower_slice done");
	endtask

	// clock edges with execute low but enable low must leave pins and state alone
	task automatic test_frozen();
		apply(3'h5, 3'h6, 4'h3, 1'b0);
		clk_en_i = 1'b0;
		repeat (3) begin
			@(posedge clk_i);
			#1;
			check_pins(4'hA, 4'h3, 3'h6, 1'b0);
		end
		check_nib("frozen out", ~4'hA, data_out_n_o);
		clk_en_i = 1'b1;
		execute_n_i = 1'b1;
		$display("test frozen done");
	endtask

	task automatic test_top_slice();
		top_sel = 1'b1;
		sweep(1'b1, 4'h7, 4'h1);
		sweep(1'b1, 4'h8, 4'h8);
		sweep(1'b1, 4'h3, 4'h2);
		sweep(1'b1, 4'hC, 4'h3);
		$display("test top_slice done");
	endtask

	// two passes through one slice stand in for a two-slice ripple array:
	// 7B plus C5 with the array carry in set; status pins are not judged here
	task automatic test_ripple();
		logic       carry_n;                // ripple carry of the low pass
		logic [8:0] sum;                    // expected array sum with carry out
		sum = 9'h07B + 9'h0C5 + 9'h001;
		apply(3'h1, 3'h3, 4'hB, 1'b0);
		apply(3'h2, 3'h3, 4'h7, 1'b0);
		apply(3'h1, 3'h0, 4'h5, 1'b0);
		#5;
		check_bit("low carry", 1'b0, ripple_n);
		carry_n = ripple_n;
		apply(3'h2, {2'h0, carry_n}, 4'hC, 1'b0);
		#5;
		check_bit("array carry", ~sum[8], ripple_n);
		apply(3'h1, 3'h4, 4'h0, 1'b0);
		check_nib("high sum", ~sum[7:4], data_out_n_o);
		apply(3'h1, 3'h4, 4'h0, 1'b1);
		check_nib("low sum", ~sum[3:0], data_out_n_o);
		$display("test ripple done");
	endtask

	// mid-run reset clears the stack and the output register
	task automatic test_reset();
		apply(3'h0, 3'h4, 4'h0, 1'b1);
		arst_n_i = 1'b0;
		apply(3'h0, 3'h4, 4'h0, 1'b1);
		check_nib("reset out", 4'hF, data_out_n_o);
		arst_n_i = 1'b1;
		// internal reset lifts two edges later, so the commit comes third
		repeat (2) apply(3'h2, 3'h4, 4'h0, 1'b1);
		apply(3'h2, 3'h4, 4'h0, 1'b0);
		apply(3'h2, 3'h4, 4'h0, 1'b1);
		check_nib("cleared reg", 4'hF, data_out_n_o);
		$display("test reset done");
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hang guard well beyond the planned run
	initial begin
		#100000;
		mismatches++;
		results();
	end

	initial begin
		mismatches = 0;
		comparisons = 0;
		arst_n_i = 1'b0;
		clk_en_i = 1'b1;
		execute_n_i = 1'b1;
		sel = 3'h0;
		operand_in_n_i = 4'hF;
		{bit2, bit1, bit0} = 3'h2;
		top_sel = 1'b0;
		oe_n = 1'b1;
		repeat (20) @(posedge clk_i);
		#1;
		check_nib("reset out", 4'hF, data_out_n_o);
		check_bit("reset enable", 1'b0, data_out_oe_o);
		arst_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		test_store();
		test_lower_slice();
		test_frozen();
		test_top_slice();
		test_ripple();
		test_reset();
		results();
	end
endmodule
